// >>> src/rsrc_top.sv
// module: reset state and core regulator control
// Function
// - regulator off in sleep mode, kept on in suspend mode.
// - bias force bit at 1 keeps precision oscillator bias on outside sleep mode.
// - reserved bits 6, 5, 0 read zero; software writes zero.
// - unused bits 7 and 3..1 read zero, writes ignored.
// - reset halts execution and loads registers with reset values.
// - reset forces known port state, interrupts and timers disabled.
// - reset leaves internal data memory unchanged.
// - reset returns stack pointer to its reset value.
// - reset sets port latches to 0xFF in open-drain mode.
// - weak pull-ups enabled during and after reset.
// - power-on reset leaves reset pin undriven, pull-up off.
// - supply monitor reset drives reset pin low until reset ends.
// - leaving reset clears program counter, selects internal oscillator.
// - leaving reset, watchdog runs on system clock divided by 12.
// - after any reset fetching starts at code address 0x0000.
// - power-on exit sets power-on flag; other resets clear it.
// - enabled, selected monitor with low supply outside sleep holds reset, pin low.
`timescale 1ns/1ps
module rsrc_top
   import rsrc_pkg::*;
#(
   parameter int BIAS_SETTLE_CYC = RSRC_BIAS_SETTLE_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic por_req,
   input wire logic supply_low,
   input wire logic mon_enable,
   input wire logic mon_select,
   input wire logic other_rst_req,
   input wire rsrc_pm_t power_mode,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic core_regulator_en,
   output logic precision_osc_bias_en,
   output logic bias_settled,
   output logic sys_rst,
   output logic cpu_halt,
   output logic [15:0] pc_init,
   output logic [7:0] sp_init,
   output logic [1:0] clk_sel,
   output logic wdt_en,
   output logic [3:0] wdt_div,
   output logic irq_en,
   output logic timers_en,
   output logic [7:0] port_latch,
   output logic port_open_drain,
   output logic weak_pullup_en,
   output logic rst_pin_o,
   output logic rst_pin_oe,
   output logic rst_pin_pullup,
   output logic power_on_reset_flag
);
   rsrc_rel_if rel();
   logic por_m_q;
   logic por_s_q;
   logic low_m_q;
   logic low_s_q;
   logic oth_m_q;
   logic oth_s_q;
   logic mon_hit;
   logic por_seen_q;
   logic mon_seen_q;
   logic [7:0] regctl_q;
   logic bias_prev_q;
   logic [$clog2(BIAS_SETTLE_CYC+1)-1:0] settle_q;

   // pin inputs pass two flip-flops
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         por_m_q <= 1'b1;
         por_s_q <= 1'b1;
         low_m_q <= 1'b0;
         low_s_q <= 1'b0;
         oth_m_q <= 1'b0;
         oth_s_q <= 1'b0;
      end
      else
      begin
         por_m_q <= por_req;
         por_s_q <= por_m_q;
         low_m_q <= supply_low;
         low_s_q <= low_m_q;
         oth_m_q <= other_rst_req;
         oth_s_q <= oth_m_q;
      end
   end

   // monitor counts only when enabled, selected and awake
   assign mon_hit = low_s_q & mon_enable & mon_select
      & (power_mode != RSRC_PM_SLEEP);
   assign rel.src_any = por_s_q | mon_hit | oth_s_q;
   assign rel.por_src = por_s_q;
   assign rel.mon_src = mon_hit;

   rsrc_sync u_sync (
      .clk(clk),
      .rst(rst),
      .rel(rel)
   );

   assign sys_rst = rel.sys_rst;

   // remember which source caused the current reset, set wins over clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         por_seen_q <= 1'b1;
         mon_seen_q <= 1'b0;
      end
      else
      begin
         if (rel.release_pulse)
         begin
            por_seen_q <= 1'b0;
            mon_seen_q <= 1'b0;
         end
         if (rel.por_src)
            por_seen_q <= 1'b1;
         if (rel.mon_src)
            mon_seen_q <= 1'b1;
      end
   end

   // power-on flag updated on exit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         power_on_reset_flag <= 1'b0;
      else if (rel.release_pulse)
         power_on_reset_flag <= por_seen_q;
   end

   // reset pin: undriven on power-on, low on monitor reset
   always_comb
   begin
      rst_pin_o = 1'b0;
      rst_pin_oe = 1'b0;
      rst_pin_pullup = 1'b1;
      if (sys_rst && por_seen_q)
      begin
         rst_pin_pullup = 1'b0;
      end
      else if (sys_rst && (mon_seen_q || mon_hit))
      begin
         rst_pin_oe = 1'b1;
         rst_pin_pullup = 1'b0;
      end
   end

   // core regulator control register, only bias bit stored
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         regctl_q <= RSRC_REGCTL_RST;
      else if (sys_rst)
         regctl_q <= RSRC_REGCTL_RST;
      else if (sfr_wr && sfr_addr == RSRC_REGCTL_ADDR)
         regctl_q <= sfr_wdata & RSRC_REGCTL_WMASK;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sfr_rdata <= 8'h00_00;
      else if (sfr_rd && sfr_addr == RSRC_REGCTL_ADDR)
         sfr_rdata <= regctl_q & RSRC_REGCTL_WMASK;
      else
         sfr_rdata <= 8'h00_00;
   end

   assign core_regulator_en = (power_mode != RSRC_PM_SLEEP);
   assign precision_osc_bias_en = regctl_q[RSRC_BIAS_BIT]
      & (power_mode != RSRC_PM_SLEEP);

   // settling status after bias comes back on
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bias_prev_q <= 1'b1;
         settle_q <= '0;
      end
      else
      begin
         bias_prev_q <= precision_osc_bias_en;
         if (precision_osc_bias_en && !bias_prev_q)
            settle_q <= ($clog2(BIAS_SETTLE_CYC+1))'(BIAS_SETTLE_CYC);
         else if (!precision_osc_bias_en)
            settle_q <= '0;
         else if (settle_q != '0)
            settle_q <= settle_q - 1'b1;
      end
   end
   assign bias_settled = precision_osc_bias_en && bias_prev_q && settle_q == '0;

   // reset state of core, ports, timers and clocking
   always_comb
   begin
      cpu_halt = sys_rst;
      irq_en = ~sys_rst;
      timers_en = ~sys_rst;
      pc_init = RSRC_PC_RST;
      sp_init = RSRC_SP_RST;
      clk_sel = RSRC_CLKSEL_INT_OSC;
      wdt_en = ~sys_rst;
      wdt_div = RSRC_WDT_DIV;
      port_latch = RSRC_PORT_LATCH_RST;
      port_open_drain = 1'b1;
      weak_pullup_en = 1'b1;
   end
   // no memory in this block is touched by reset

   property flag_on_exit_p;
      @(posedge clk) disable iff (rst)
      rel.release_pulse |=> power_on_reset_flag == $past(por_seen_q);
   endproperty
   por_flag_a: assert property (flag_on_exit_p)
      else $error("power-on flag wrong after release");
   sleep_reg_a: assert property (@(posedge clk) disable iff (rst)
      (power_mode == RSRC_PM_SLEEP) |-> !core_regulator_en)
      else $error("regulator on in sleep");
   susp_reg_a: assert property (@(posedge clk) disable iff (rst)
      (power_mode == RSRC_PM_SUSPEND) |-> core_regulator_en)
      else $error("regulator off in suspend");
   bias_force_a: assert property (@(posedge clk) disable iff (rst)
      (regctl_q[RSRC_BIAS_BIT] && power_mode != RSRC_PM_SLEEP) |-> precision_osc_bias_en)
      else $error("bias off while forced");
   bias_rise_a: assert property (@(posedge clk) disable iff (rst)
      $rose(precision_osc_bias_en) |-> !bias_settled)
      else $error("bias settled at once after re-enable");
   rsvd_read_a: assert property (@(posedge clk) disable iff (rst)
      (sfr_rdata & ~RSRC_REGCTL_WMASK) == 8'h00_00)
      else $error("reserved bits read nonzero");
   unused_q_a: assert property (@(posedge clk) disable iff (rst)
      (regctl_q & ~RSRC_REGCTL_WMASK) == 8'h00_00)
      else $error("unused bits stored");
   rst_reg_a: assert property (@(posedge clk) disable iff (rst)
      sys_rst |=> regctl_q == RSRC_REGCTL_RST)
      else $error("register not held at reset value");
   por_pin_a: assert property (@(posedge clk) disable iff (rst)
      (sys_rst && por_seen_q) |-> (!rst_pin_oe && !rst_pin_pullup))
      else $error("reset pin driven during power-on");
   mon_pin_a: assert property (@(posedge clk) disable iff (rst)
      (sys_rst && mon_seen_q && !por_seen_q) |-> (rst_pin_oe && !rst_pin_o))
      else $error("reset pin not low on monitor reset");
   pin_idle_a: assert property (@(posedge clk) disable iff (rst)
      !sys_rst |-> !rst_pin_oe)
      else $error("reset pin driven outside reset");
   sequence low_seen_s;
      mon_hit ##1 1'b1;
   endsequence
   mon_hold_a: assert property (@(posedge clk) disable iff (rst)
      low_seen_s |=> sys_rst)
      else $error("monitor did not hold reset");
   sequence src_seen_s;
      rel.src_any ##1 1'b1;
   endsequence
   sequence src_quiet_s;
      !rel.src_any [*2];
   endsequence
   src_hold_a: assert property (@(posedge clk) disable iff (rst)
      src_seen_s |=> sys_rst)
      else $error("reset not held while a source is active");
   rel_sync_a: assert property (@(posedge clk) disable iff (rst)
      src_quiet_s |=> !sys_rst)
      else $error("reset not released after sources went quiet");
   halt_rst_a: assert property (@(posedge clk) disable iff (rst)
      sys_rst |-> (cpu_halt && !irq_en && !timers_en && port_latch == RSRC_PORT_LATCH_RST))
      else $error("reset state not applied");
   port_rst_a: assert property (@(posedge clk) disable iff (rst)
      sys_rst |-> (port_open_drain && weak_pullup_en))
      else $error("ports not open-drain with pull-ups in reset");
   pullup_run_a: assert property (@(posedge clk) disable iff (rst)
      !sys_rst |-> weak_pullup_en)
      else $error("pull-ups off after reset");
   sp_rst_a: assert property (@(posedge clk) disable iff (rst)
      sys_rst |-> sp_init == RSRC_SP_RST)
      else $error("stack pointer not at reset value");
   run_en_a: assert property (@(posedge clk) disable iff (rst)
      !sys_rst |-> (irq_en && timers_en && wdt_en))
      else $error("run enables missing outside reset");
   wdt_run_a: assert property (@(posedge clk) disable iff (rst)
      $fell(sys_rst) |-> (wdt_en && wdt_div == RSRC_WDT_DIV && pc_init == RSRC_PC_RST))
      else $error("watchdog or pc wrong at release");
   clk_sel_a: assert property (@(posedge clk) disable iff (rst)
      $fell(sys_rst) |-> clk_sel == RSRC_CLKSEL_INT_OSC)
      else $error("clock source wrong at release");
endmodule : rsrc_top

// >>> src/rsrc_pkg.sv
// package: constants for the reset state and regulator control block
package rsrc_pkg;
   localparam logic [7:0] RSRC_REGCTL_ADDR = 8'h00_C9;
   localparam int RSRC_BIAS_BIT = 4;
   localparam logic [7:0] RSRC_REGCTL_WMASK = 8'h00_10;
   localparam logic [7:0] RSRC_REGCTL_RST = 8'h00_10;
   localparam logic [7:0] RSRC_PORT_LATCH_RST = 8'h00_FF;
   localparam logic [7:0] RSRC_SP_RST = 8'h00_07;
   localparam logic [15:0] RSRC_PC_RST = 16'h0000;
   localparam logic [3:0] RSRC_WDT_DIV = 4'h0_C;
   localparam logic [1:0] RSRC_CLKSEL_INT_OSC = 2'h0;
   localparam int RSRC_BIAS_SETTLE_NS = 4000;
   localparam int RSRC_CLK_NS = 25;
   localparam int RSRC_BIAS_SETTLE_CYC = (RSRC_BIAS_SETTLE_NS + RSRC_CLK_NS - 1) / RSRC_CLK_NS;
   typedef enum logic [1:0] {RSRC_PM_RUN, RSRC_PM_SUSPEND, RSRC_PM_SLEEP} rsrc_pm_t;
endpackage : rsrc_pkg

// >>> src/rsrc_rel_if.sv
// interface: release path between reset combiner and the sequencer
`timescale 1ns/1ps
interface rsrc_rel_if;
   logic src_any;
   logic por_src;
   logic mon_src;
   logic sys_rst;
   logic release_pulse;
   modport combiner (input src_any, output sys_rst, output release_pulse);
   modport seq (output src_any, output por_src, output mon_src,
      input sys_rst, input release_pulse);
endinterface : rsrc_rel_if

// >>> src/rsrc_sync.sv
// module: reset combiner with synchronous release
`timescale 1ns/1ps
module rsrc_sync
   import rsrc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   rsrc_rel_if.combiner rel
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   // assert asynchronously on rst only; sources assert and release after two clean edges
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
      end
      else
      begin
         s1_q <= rel.src_any;
         s2_q <= s1_q;
      end
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s3_q <= 1'b1;
      else
         s3_q <= s2_q;
   end
   assign rel.sys_rst = s2_q;
   assign rel.release_pulse = s3_q & ~s2_q;
endmodule : rsrc_sync

// >>> dv/rsrc_far_model.sv
// far side model: supply monitor output and reset pin wire
`timescale 1ns/1ps
module rsrc_far_model (
   input wire logic clk,
   input wire logic drop,
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe,
   input wire logic rst_pin_pullup,
   output logic supply_low,
   output logic pin_level
);
   logic last_q = 1'b0;
   // supply dips below threshold while commanded
   assign supply_low = drop;
   // undriven, no pull-up: the wire flips, so it is never a stale level
   assign pin_level = rst_pin_oe ? rst_pin_o : (rst_pin_pullup ? 1'b1 : ~last_q);
   always @(posedge clk)
   begin
      last_q <= pin_level;
   end
endmodule : rsrc_far_model

// >>> dv/tb_top.sv
// testbench: reset state and regulator control
`timescale 1ns/1ps
module tb_top;
   import rsrc_pkg::*;
   logic clk, rst, por, mon_en, mon_sel, oth, drop, wr, rd, sl, lvl;
   rsrc_pm_t pm;
   logic [7:0] addr, wd, rdat, latch, sp;
   logic [15:0] pc;
   logic [1:0] csel;
   logic [3:0] wdiv;
   logic reg_en, bias_en, setl, srst, halt, wdt_en, irq_en, tmr_en;
   logic od, wpu, p_o, p_oe, p_pu, flag;
   logic [7:0] d;
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;
   rsrc_top #(.BIAS_SETTLE_CYC(4)) u_dut (.clk(clk), .rst(rst), .por_req(por),
      .supply_low(sl), .mon_enable(mon_en), .mon_select(mon_sel), .other_rst_req(oth),
      .power_mode(pm), .sfr_wr(wr), .sfr_rd(rd), .sfr_addr(addr), .sfr_wdata(wd),
      .sfr_rdata(rdat), .core_regulator_en(reg_en), .precision_osc_bias_en(bias_en),
      .bias_settled(setl), .sys_rst(srst), .cpu_halt(halt), .pc_init(pc),
      .sp_init(sp), .clk_sel(csel), .wdt_en(wdt_en), .wdt_div(wdiv), .irq_en(irq_en),
      .timers_en(tmr_en), .port_latch(latch), .port_open_drain(od),
      .weak_pullup_en(wpu), .rst_pin_o(p_o), .rst_pin_oe(p_oe),
      .rst_pin_pullup(p_pu), .power_on_reset_flag(flag));
   rsrc_far_model u_far (.clk(clk), .drop(drop), .rst_pin_o(p_o), .rst_pin_oe(p_oe),
      .rst_pin_pullup(p_pu), .supply_low(sl), .pin_level(lvl));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic report_and_stop;
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chkb(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask : chkb
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
      wr = 1'b1;
      addr = a;
      wd = v;
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask : sfr_write
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
      rd = 1'b1;
      addr = a;
      tick(1);
      rd = 1'b0;
      v = rdat;
      tick(1);
   endtask : sfr_read
   task automatic wait_rst(input logic v);
      for (int i = 0; i < 40 && srst !== v; i++)
         tick(1);
      chkb(srst, v);
   endtask : wait_rst
   task automatic t_after_reset;
      wait_rst(1'b0);
      tick(2);
      chkb(flag, 1'b1);
      chkb(wdt_en, 1'b1);
      chk({12'h000, wdiv}, 16'h000C);
      chk(pc, 16'h0000);
      chk({8'h00, sp}, {8'h00, RSRC_SP_RST});
      chk({14'h0000, csel}, 16'h0000);
      chkb(lvl, 1'b1);
      chkb(wpu, 1'b1);
      sfr_read(8'hC9, d);
      chk({8'h00, d}, 16'h0010);
   endtask : t_after_reset
   task automatic t_regwrite;
      sfr_write(8'hC9, 8'h8E);
      sfr_read(8'hC9, d);
      chk({8'h00, d}, 16'h0000);
      chkb(bias_en, 1'b0);
      sfr_write(8'hC9, 8'h10);
      chkb(bias_en, 1'b1);
      chkb(setl, 1'b0);
      tick(6);
      chkb(setl, 1'b1);
      sfr_read(8'hC8, d);
      chk({8'h00, d}, 16'h0000);
   endtask : t_regwrite
   task automatic t_modes;
      for (int m = 0; m < 3; m++)
      begin
         pm = rsrc_pm_t'(m);
         tick(1);
         chkb(reg_en, pm != RSRC_PM_SLEEP);
         chkb(bias_en, pm != RSRC_PM_SLEEP);
      end
      drop = 1'b1;
      tick(8);
      chkb(srst, 1'b0);
      drop = 1'b0;
      tick(3);
      pm = RSRC_PM_RUN;
      tick(1);
   endtask : t_modes
   task automatic t_monitor;
      sfr_write(8'hC9, 8'h00);
      drop = 1'b1;
      wait_rst(1'b1);
      chkb(p_oe, 1'b1);
      chkb(lvl, 1'b0);
      chkb(halt, 1'b1);
      chkb(irq_en | tmr_en, 1'b0);
      drop = 1'b0;
      wait_rst(1'b0);
      tick(2);
      chkb(flag, 1'b0);
      sfr_read(8'hC9, d);
      chk({8'h00, d}, 16'h0010);
   endtask : t_monitor
   task automatic t_other;
      por = 1'b1;
      wait_rst(1'b1);
      chkb(p_oe | p_pu, 1'b0);
      por = 1'b0;
      wait_rst(1'b0);
      tick(2);
      chkb(flag, 1'b1);
      oth = 1'b1;
      wait_rst(1'b1);
      tick(5);
      chkb(srst, 1'b1);
      sfr_write(8'hC9, 8'h00);
      sfr_read(8'hC9, d);
      chk({8'h00, d}, 16'h0010);
      oth = 1'b0;
      wait_rst(1'b0);
      tick(2);
      chkb(flag, 1'b0);
   endtask : t_other
   initial
   begin
      {rst, por, oth, drop, wr, rd} = 6'b100000;
      {mon_en, mon_sel} = 2'b11;
      pm = RSRC_PM_RUN;
      addr = 8'h00;
      wd = 8'h00;
      tick(8);
      chkb(halt, 1'b1);
      chkb(irq_en | tmr_en, 1'b0);
      chkb(p_oe | p_pu, 1'b0);
      chk({8'h00, latch}, 16'h00FF);
      chkb(od & wpu, 1'b1);
      tick(8);
      rst = 1'b0;
      t_after_reset();
      t_regwrite();
      t_modes();
      t_monitor();
      t_other();
      report_and_stop();
   end
endmodule : tb_top
